// ==== hw/rstgen_pkg.sv ====
// constants and types of the event triggered reset generator
// assumes a 20 MHz core clock and a same-clock event state vector
package rstgen_pkg;
  localparam logic [7:0]  ADDR_EVENT_A    = 8'h2B;
  localparam logic [7:0]  ADDR_EVENT_B    = 8'h2C;
  localparam logic [7:0]  ADDR_EVENT_C    = 8'h2D;
  localparam logic [7:0]  ADDR_RESET_CFG  = 8'h2E;
  localparam logic [7:0]  CFG_RESET_VALUE = 8'h00;
  localparam logic [7:0]  SEL_RESET_VALUE = 8'h00;
  localparam int          NUM_TRIGGERS    = 3;
  localparam int          POL_BIT         = 7;
  localparam int          OVR_BIT         = 6;
  localparam int          HOLD_MSB        = 5;
  localparam int          HOLD_LSB        = 2;
  localparam int          WIDTH_MSB       = 1;
  localparam int          WIDTH_LSB       = 0;
  localparam int          LEVEL_BIT       = 7;
  localparam int          CLK_MHZ         = 20;
  // base tick of all timing, in microseconds
  localparam int          TICK_US         = 500;
  localparam int          TICK_CYCLES     = TICK_US * CLK_MHZ;
  // one half second expressed in base ticks
  localparam int          HALF_SEC_MS     = 500;
  localparam logic [14:0] TICKS_PER_HALF  = 15'(HALF_SEC_MS * 1000 / TICK_US);
  // pulse widths in base ticks: 500 us, 1 ms, 2 ms, 10 ms
  localparam logic [14:0] WIDTH_TICKS_00  = 15'(500 / TICK_US);
  localparam logic [14:0] WIDTH_TICKS_01  = 15'(1000 / TICK_US);
  localparam logic [14:0] WIDTH_TICKS_10  = 15'(2000 / TICK_US);
  localparam logic [14:0] WIDTH_TICKS_11  = 15'(10000 / TICK_US);
  localparam logic [3:0]  HOLD_CODE_LAST_HALF = 4'h6;

  typedef struct packed {
    logic       polarity;
    logic       override;
    logic [3:0] hold;
    logic [1:0] width;
  } reset_cfg_type;

  typedef struct packed {
    logic       level;
    logic [6:0] code;
  } trigger_sel_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HOLD,
    ST_PULSE,
    ST_RELEASE
  } gen_state_type;
endpackage

// ==== hw/event_triggered_reset_generator.sv ====
// event triggered reset generator with its configuration registers
// assumes event_state_i comes from logic on mclk_i, pin input is asynchronous
`timescale 1ns/1ns
module event_triggered_reset_generator
  import rstgen_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [7:0]   reg_addr_i,
  input  wire logic [7:0]   reg_wdata_i,
  input  wire logic         reg_wr_i,
  output logic      [7:0]   reg_rdata_o,
  input  wire logic [127:1] event_state_i,
  input  wire logic         rst_pin_n_i,
  output logic              reset_o,
  output logic              pulse_active_o
);

  reset_cfg_type   cfg;
  trigger_sel_type sel [NUM_TRIGGERS];
  gen_state_type   state;
  logic [2:0]      pin_sync;
  logic            pin_asserted;
  logic [NUM_TRIGGERS-1:0] trig_ok;
  logic            any_enabled;
  logic            all_active;
  logic            hold_done;
  logic [31:0]     prescale;
  logic            tick;
  logic [14:0]     tick_count;
  logic [14:0]     hold_ticks;
  logic [14:0]     width_ticks;
  logic            restart_prescale;
  logic [7:0]      next_rdata;

  // register writes
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cfg <= reset_cfg_type'(CFG_RESET_VALUE);
    end else if (reg_wr_i && reg_addr_i == ADDR_RESET_CFG) begin
      cfg.polarity <= reg_wdata_i[POL_BIT];
      cfg.override <= reg_wdata_i[OVR_BIT];
      cfg.hold     <= reg_wdata_i[HOLD_MSB:HOLD_LSB];
      cfg.width    <= reg_wdata_i[WIDTH_MSB:WIDTH_LSB];
    end
  end

  generate
    for (genvar i = 0; i < NUM_TRIGGERS; i++) begin : g_trig
      localparam logic [7:0] SEL_ADDR = ADDR_EVENT_A + 8'(i);
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          sel[i] <= trigger_sel_type'(SEL_RESET_VALUE);
        end else if (reg_wr_i && reg_addr_i == SEL_ADDR) begin
          sel[i] <= trigger_sel_type'(reg_wdata_i);
        end
      end
      assign trig_ok[i] = (sel[i].code == 7'h00) ||
                          (event_state_i[sel[i].code] == sel[i].level);
    end
  endgenerate

  // register reads, registered; unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr_i)
      ADDR_EVENT_A:   next_rdata = sel[0];
      ADDR_EVENT_B:   next_rdata = sel[1];
      ADDR_EVENT_C:   next_rdata = sel[2];
      ADDR_RESET_CFG: next_rdata = cfg;
      default:        next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= next_rdata;
    end
  end

  // with no selector programmed nothing can trigger
  assign any_enabled = (sel[0].code != 7'h00) || (sel[1].code != 7'h00) ||
                       (sel[2].code != 7'h00);
  assign all_active  = any_enabled && (&trig_ok);

  // external pin: three flops, accepted when second and third agree
  // flops reset to the released pin level, so no false assert follows reset
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pin_sync     <= 3'b111;
      pin_asserted <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[1:0], rst_pin_n_i};
      if (pin_sync[1] == pin_sync[2]) begin
        pin_asserted <= ~pin_sync[2];
      end
    end
  end

  // hold time table in base ticks
  always_comb begin
    if (cfg.hold <= HOLD_CODE_LAST_HALF) begin
      hold_ticks = 15'((cfg.hold + 4'h1) * TICKS_PER_HALF);
    end else begin
      hold_ticks = 15'((cfg.hold - 4'h3) * 2 * TICKS_PER_HALF);
    end
  end

  always_comb begin
    case (cfg.width)
      2'b00:   width_ticks = WIDTH_TICKS_00;
      2'b01:   width_ticks = WIDTH_TICKS_01;
      2'b10:   width_ticks = WIDTH_TICKS_10;
      default: width_ticks = WIDTH_TICKS_11;
    endcase
  end

  // prescaler realigned when a hold or pulse begins, so the first tick
  // of either is a full tick long; not while pulsing, since a retrigger
  // while pulsing must not stretch the pulse
  assign hold_done        = tick && (tick_count + 15'h1 >= hold_ticks);
  assign restart_prescale = (state == ST_IDLE && all_active) ||
                            (state == ST_HOLD && hold_done);
  assign tick = (prescale == 32'(TICK_CYCLES_P - 1));

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prescale <= 32'h0;
    end else begin
      if (restart_prescale || tick) begin
        prescale <= 32'h0;
      end else begin
        prescale <= prescale + 32'h1;
      end
    end
  end

  // sequencer
  // tick_count holds whole ticks of the current phase
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state      <= ST_IDLE;
      tick_count <= 15'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          tick_count <= 15'h0;
          if (all_active) begin
            state <= (cfg.hold == 4'h0) ? ST_PULSE : ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!all_active) begin
            state      <= ST_IDLE;
            tick_count <= 15'h0;
          end else if (tick) begin
            if (tick_count + 15'h1 >= hold_ticks) begin
              state      <= ST_PULSE;
              tick_count <= 15'h0;
            end else begin
              tick_count <= tick_count + 15'h1;
            end
          end
        end
        ST_PULSE: begin
          if (tick) begin
            if (tick_count + 15'h1 >= width_ticks) begin
              state      <= ST_RELEASE;
              tick_count <= 15'h0;
            end else begin
              tick_count <= tick_count + 15'h1;
            end
          end
        end
        // one pulse per trigger: wait for release
        ST_RELEASE: begin
          tick_count <= 15'h0;
          if (!all_active) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state      <= ST_IDLE;
          tick_count <= 15'h0;
        end
      endcase
    end
  end

  // output stage
  // pulse_active_o leaves out the pin path on purpose
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      reset_o        <= 1'b1;
      pulse_active_o <= 1'b0;
    end else begin
      pulse_active_o <= (state == ST_PULSE);
      reset_o <= ~(((state == ST_PULSE) || (cfg.override && pin_asserted)) ^ cfg.polarity);
    end
  end

endmodule // event_triggered_reset_generator

// ==== tb/rstgen_chk.sv ====
// port checker of the event triggered reset generator
// assumes a bind onto the generator top and a small tick parameter
`timescale 1ns/1ns
module rstgen_chk
  import rstgen_pkg::*;
#(parameter int T = 4) (
  input wire logic         mclk_i,
  input wire logic         rst_n_i,
  input wire logic [7:0]   reg_addr_i,
  input wire logic [7:0]   reg_wdata_i,
  input wire logic         reg_wr_i,
  input wire logic [7:0]   reg_rdata_o,
  input wire logic [127:1] event_state_i,
  input wire logic         rst_pin_n_i,
  input wire logic         reset_o,
  input wire logic         pulse_active_o
);
  reset_cfg_type cfg;
  logic [127:1]  evq;
  int            wcnt, scnt, w;
  assign w = (cfg.width == 2'h3 ? 20 : 1 << cfg.width) * T;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) cfg <= CFG_RESET_VALUE;
    else if (reg_wr_i && reg_addr_i == ADDR_RESET_CFG) cfg <= reg_wdata_i;
  end
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wcnt <= 0;
      scnt <= 0;
    end else begin
      wcnt <= pulse_active_o ? wcnt + 1 : 0;
      scnt <= event_state_i == evq ? scnt + 1 : 0;
    end
    evq <= event_state_i;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_reset_vals: assert property (disable iff (1'b0)
    !rst_n_i |=> reset_o && !pulse_active_o) else $error("reset state wrong");
  a_write_back: assert property (reg_wr_i && reg_addr_i inside {[8'h2B:8'h2E]} ##1
    !reg_wr_i && $stable(reg_addr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("readback wrong");
  a_unmapped_zero: assert property (reg_addr_i < 8'h2B || reg_addr_i > 8'h2E
    |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_pulse_level: assert property (pulse_active_o |-> reset_o == cfg.polarity)
    else $error("pulse level wrong");
  a_idle_level: assert property (
    (!pulse_active_o && (rst_pin_n_i || !cfg.override) && $stable(cfg))[*8]
    |-> reset_o == !cfg.polarity) else $error("idle level wrong");
  a_pin_or: assert property ((cfg.override && !rst_pin_n_i && $stable(cfg))[*8]
    |-> reset_o == cfg.polarity) else $error("pin not passed");
  a_width_range: assert property ($fell(pulse_active_o) |-> wcnt inside {[w-1:w+1]})
    else $error("pulse width wrong");
  a_hold_min: assert property ($rose(pulse_active_o) && cfg.hold != 4'h0
    |-> scnt >= 2000 * T) else $error("hold too short");
endmodule // rstgen_chk
bind event_triggered_reset_generator rstgen_chk #(.T(TICK_CYCLES_P)) chk (.mclk_i, .rst_n_i,
  .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rdata_o, .event_state_i, .rst_pin_n_i, .reset_o,
  .pulse_active_o);

// ==== tb/reset_sink.sv ====
// far side model: logic that receives the generated reset
// assumes active_high_i follows the configured polarity
`timescale 1ns/1ns
module reset_sink (
  input  wire logic mclk_i,
  input  wire logic line_i,
  input  wire logic active_high_i,
  output int        width_o,
  output int        count_o
);
  int run;
  always @(posedge mclk_i) begin
    if (line_i === active_high_i) begin
      run <= run + 1;
    end else if (run != 0) begin
      width_o <= run;
      count_o <= count_o + 1;
      run <= 0;
    end
  end
endmodule // reset_sink

// ==== tb/tb.sv ====
// self checking bench of the event triggered reset generator
// assumes the reset sink model and the bound port checker
`timescale 1ns/1ns
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb;
  import rstgen_pkg::*;
  localparam int T = 2;
  logic         mclk_i = 0, rst_n_i = 0, reg_wr_i = 0, rst_pin_n_i = 1;
  logic [7:0]   reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic [127:1] event_state_i = '0;
  logic         reset_o, pulse_active_o;
  logic [7:0]   model [4] = '{default: 8'h00};
  int           err_total = 0, comparisons = 0, width, count, c0;
  int           ticks [4] = '{1, 2, 4, 20};
  logic [3:0]   hold_code [2] = '{4'h6, 4'h7};
  int           hold_ms [2] = '{3500, 4000};
  event_triggered_reset_generator #(.TICK_CYCLES_P(T)) dut (.mclk_i, .rst_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rdata_o, .event_state_i, .rst_pin_n_i, .reset_o,
    .pulse_active_o);
  reset_sink sink (.mclk_i, .line_i(reset_o), .active_high_i(model[3][7]), .width_o(width),
    .count_o(count));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
    @(posedge mclk_i) reg_wr_i <= 1'b0;
    if (a inside {[8'h2B:8'h2E]}) model[a - 8'h2B] = d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i) reg_addr_i <= a;
    @(posedge mclk_i) #1 d = reg_rdata_o;
  endtask
  task automatic wait_pulse(input int lim, output int cyc);
    for (cyc = 0; pulse_active_o !== 1'b1; cyc++) begin
      if (cyc == lim) begin
        err_total++;
        print_verdict();
      end
      @(posedge mclk_i) #1;
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial forever #25 mclk_i = ~mclk_i;
  initial begin
    logic [7:0]   d;
    logic [127:1] ev;
    int           cyc;
    void'($urandom(32'hEB1A));
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int a = 8'h2B; a <= 8'h2E; a++) begin
      rd(8'(a), d);
      `CHK("reset value", 8'h00, d)
      wr(8'(a), 8'($urandom));
      rd(8'(a), d);
      `CHK("readback", model[a - 8'h2B], d)
    end
    rd(8'h2F, d);
    `CHK("unmapped", 8'h00, d)
    wr(8'h2E, 8'h80);
    wr(8'h2B, 8'h85);
    wr(8'h2C, 8'h09);
    wr(8'h2D, 8'h00);
    repeat (100) @(posedge mclk_i);
    ev = 127'({$urandom, $urandom, $urandom, $urandom});
    ev[5] = 1'b1;
    ev[9] = 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(8'h2E, 8'(8'h80 | k));
      c0 = count;
      @(posedge mclk_i) event_state_i <= ev;
      wait_pulse(8, cyc);
      `CHK("start delay", 2, cyc)
      repeat (T * ticks[k] + 4) @(posedge mclk_i);
      `CHK("pulse width", T * ticks[k], width)
      `CHK("single pulse", c0 + 1, count)
      event_state_i <= '0;
    end
    wr(8'h2E, 8'h04);
    @(posedge mclk_i) event_state_i <= ev;
    repeat (1000 * T) @(posedge mclk_i);
    event_state_i <= '0;
    @(posedge mclk_i) event_state_i <= ev;
    wait_pulse(2000 * T + 8, cyc);
    `CHK("hold restart", 1'b1, cyc >= 2000 * T && cyc <= 2000 * T + 4)
    `CHK("low active", 1'b0, reset_o)
    repeat (T + 4) @(posedge mclk_i);
    event_state_i <= '0;
    foreach (hold_code[j]) begin
      wr(8'h2E, {2'b00, hold_code[j], 2'b00});
      @(posedge mclk_i) event_state_i <= ev;
      wait_pulse(hold_ms[j] * 1000 / TICK_US * T + 8, cyc);
      `CHK("hold time", hold_ms[j] * 1000 / TICK_US * T + 2, cyc)
      repeat (T + 4) @(posedge mclk_i);
      event_state_i <= '0;
    end
    wr(8'h2E, 8'h40);
    @(posedge mclk_i) rst_pin_n_i <= 1'b0;
    repeat (6) @(posedge mclk_i) #1;
    `CHK("pin passes", 1'b0, reset_o)
    wr(8'h2E, 8'h00);
    repeat (3) @(posedge mclk_i) #1;
    `CHK("pin blocked", 1'b1, reset_o)
    for (int a = 0; a < 3; a++) wr(8'(8'h2B + a), 8'h00);
    @(posedge mclk_i) event_state_i <= '1;
    repeat (20) @(posedge mclk_i) #1;
    `CHK("no selector", 1'b0, pulse_active_o)
    print_verdict();
  end
endmodule // tb
